// [rtl/serial_ctrl_pkg.sv]
// constants shared by the serial control interface
package serial_ctrl_pkg;
   localparam int FRAME_BITS = 16;
   localparam int ADDR_MSB = 15;
   localparam int ADDR_LSB = 12;
   localparam int WD_BIT = 11;
   localparam int SUB_BIT = 10;
   localparam int DATA_W = 11;
   localparam int FIFO_DEPTH = 32;
   localparam int NUM_REGS = 16;
   localparam logic [3:0] ADDR_INIT_ONE = 4'h0;
   localparam logic [3:0] ADDR_INIT_TWO = 4'h1;
   localparam logic [3:0] ADDR_CH1 = 4'h2;
   localparam logic [3:0] ADDR_CH2 = 4'h3;
   localparam logic [3:0] ADDR_CH3 = 4'h4;
   localparam logic [3:0] ADDR_CH4 = 4'h5;
   localparam logic [3:0] ADDR_CH6 = 4'h7;
   localparam logic [3:0] ADDR_OUT_SW = 4'h8;
   localparam logic [3:0] ADDR_GPWM = 4'h9;
   localparam logic [3:0] ADDR_OC = 4'ha;
   localparam logic [3:0] ADDR_IN_EN = 4'hb;
   localparam logic [3:0] ADDR_CLKDIV = 4'hc;
   localparam logic [3:0] ADDR_OL = 4'hd;
   localparam logic [3:0] ADDR_STEP = 4'he;
   localparam logic [3:0] ADDR_TEST = 4'hf;
   localparam logic [10:0] REG_RESET = 11'h000;
   localparam int OSEL_LSB = 0;
   localparam int DUTY_LSB = 0;
   localparam int CHON_BIT = 8;
   localparam int PHASE_LSB = 9;
   // watchdog timeout in microseconds at a 10 MHz clock
   localparam int CLK_MHZ = 10;
   localparam int WD_TIMEOUT_US = 32000;
   localparam int WD_TIMEOUT_CYC = WD_TIMEOUT_US * CLK_MHZ;
   localparam int WD_CNT_W = 24;
endpackage : serial_ctrl_pkg

// [rtl/frame_fifo.sv]
// parameterised valid/ready fifo for received frames
`timescale 1ns/1ps
module frame_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic [WIDTH-1:0] i_data,
   input wire logic i_valid,
   output logic o_ready,
   output logic [WIDTH-1:0] o_data,
   output logic o_valid,
   input wire logic i_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } fifo_s;
   fifo_s st_r;
   fifo_s st_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic full;
   logic empty;
   logic push;
   logic pop;

   assign empty = (st_r.wp == st_r.rp);
   assign full = (st_r.wp[AW] != st_r.rp[AW]) &&
                 (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]);
   assign push = i_valid && !full;
   assign pop = i_ready && !empty;
   assign o_ready = !full;
   assign o_valid = !empty;
   assign o_data = mem[st_r.rp[AW-1:0]];

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (pop) begin
         st_nxt.rp = st_r.rp + 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (push) begin
         mem[st_r.wp[AW-1:0]] <= i_data;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule : frame_fifo

// [rtl/pin_sync.sv]
// two flip-flop synchroniser for a bundle of pins
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 4
) (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic [WIDTH-1:0] i_async,
   input wire logic [WIDTH-1:0] i_init,
   output logic [WIDTH-1:0] o_sync
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } sync_s;
   sync_s st_r;
   sync_s st_nxt;

   assign o_sync = st_r.s2;

   always_comb begin
      st_nxt.s1 = i_async;
      st_nxt.s2 = st_r.s1;
   end

   // reset value is all zeros; the i_init port is not used
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
endmodule : pin_sync

// [rtl/serial_ctrl.sv]
// serial slave control interface with watchdog and fail mode
`timescale 1ns/1ps
// Notes on behaviour
// - frames are 16 bits full duplex; data out shifts through for chains
// - input bit captured on each serial clock rise while selected
// - output changes on serial clock rise; master samples on fall
// - select falling edge loads the outgoing shift register
// - while selected, in and out shift once per serial clock
// - select rising edge commits the received word to its register
// - deselected: clock and input ignored, output released
// - reset pin low clears interface and faults; wake from channel inputs
// - reset pin high means awake with the interface enabled
// - plausibility check failure enters fail mode; fail is left low (only the watchdog sets it)
// - top nibble of the frame is the register address
// - toggle bit unchanged for the timeout period flags a failure
// - all input registers read zero after any reset
// - the eleven bits below the toggle bit are the payload
// - output-select field picks the next frame's returned word
// - entering fail mode clears input registers, keeps output words
module serial_ctrl
   import serial_ctrl_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_reset_n_pin,
   input wire logic i_sclk,
   input wire logic i_chip_select_n,
   input wire logic i_si,
   input wire logic [3:0] i_direct_channel_on_inputs,
   input wire logic i_fail_cause,
   input wire logic [NUM_REGS*FRAME_BITS-1:0] i_status_words,
   output logic o_so,
   output logic o_so_oe,
   output logic o_wake,
   output logic o_spi_fail,
   output logic o_fail_mode,
   output logic [DATA_W-1:0] o_init_config_one,
   output logic [DATA_W-1:0] o_init_config_two,
   output logic [4*DATA_W-1:0] o_channel_control,
   output logic [DATA_W-1:0] o_channel_six_control,
   output logic [DATA_W-1:0] o_output_switch_control,
   output logic [DATA_W-1:0] o_global_pwm_enables,
   output logic [DATA_W-1:0] o_global_pwm_duty,
   output logic [DATA_W-1:0] o_overcurrent_low_and_mode,
   output logic [DATA_W-1:0] o_overcurrent_high_options,
   output logic [DATA_W-1:0] o_direct_input_enable,
   output logic [DATA_W-1:0] o_clock_divider_ch1_4,
   output logic [DATA_W-1:0] o_clock_divider_ch6,
   output logic [DATA_W-1:0] o_open_load_control,
   output logic [DATA_W-1:0] o_led_open_load_control,
   output logic [DATA_W-1:0] o_duty_step_adjust,
   output logic o_frame_overflow
);
   import serial_ctrl_pkg::*;

   // =========================================================
   // types
   typedef logic [DATA_W-1:0] word_t;
   // rec_low waits for the toggle-high recovery frame
   typedef enum logic [1:0] {ST_NORMAL, ST_FAIL, ST_REC_LOW} mode_e;
   typedef struct packed {
      logic sclk_d;
      logic csn_d;
      logic [FRAME_BITS-1:0] rx_sh;
      logic [FRAME_BITS-1:0] tx_sh;
      logic [4:0] bit_cnt;
      logic so;
      logic so_oe;
      logic spi_fail;
      logic wd_last;
      logic [WD_CNT_W-1:0] wd_cnt;
      mode_e mode;
      logic overflow;
      word_t init1;
      word_t init2;
      word_t [3:0] ch;
      word_t ch6;
      word_t outsw;
      word_t gpwm_en;
      word_t gpwm_duty;
      word_t oc_lo;
      word_t oc_hi;
      word_t in_en;
      word_t div14;
      word_t div6;
      word_t ol;
      word_t olled;
      word_t step;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   // =========================================================
   // pin synchronisers and frame fifo
   logic [2:0] pins_s;
   logic [3:0] dir_s;
   logic rstn_s;
   logic sclk_s;
   logic csn_s;
   logic si_s;
   logic fifo_ready;
   logic fifo_valid;
   logic [FRAME_BITS-1:0] fifo_data;
   logic push;
   logic [FRAME_BITS-1:0] push_data;
   logic [3:0] rx_addr;
   logic rx_wd;
   word_t rx_data;
   logic sclk_rise;
   logic csn_fall;
   logic csn_rise;
   logic [3:0] osel;
   logic wd_timeout;

   // sync resets low; the zero bit count masks the false select rise
   pin_sync #(.WIDTH(3)) u_spi_sync (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_async({i_sclk, i_chip_select_n, i_si}),
      .i_init(3'h0),
      .o_sync(pins_s)
   );

   pin_sync #(.WIDTH(5)) u_ctl_sync (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_async({i_reset_n_pin, i_direct_channel_on_inputs}),
      .i_init(5'h00),
      .o_sync({rstn_s, dir_s})
   );

   assign sclk_s = pins_s[2];
   assign csn_s = pins_s[1];
   assign si_s = pins_s[0];

   // decode drains one word per cycle, so the fifo never fills
   frame_fifo #(.WIDTH(FRAME_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_data(push_data),
      .i_valid(push),
      .o_ready(fifo_ready),
      .o_data(fifo_data),
      .o_valid(fifo_valid),
      .i_ready(1'b1)
   );

   // =========================================================
   // edge detection
   assign sclk_rise = sclk_s && !st_r.sclk_d;
   assign csn_fall = !csn_s && st_r.csn_d;
   assign csn_rise = csn_s && !st_r.csn_d;
   assign osel = st_r.init1[OSEL_LSB +: 4];
   assign push_data = st_r.rx_sh;
   // only complete multiples of 16 bits are committed
   assign push = csn_rise && rstn_s && (st_r.bit_cnt[3:0] == 4'h0) &&
                 (st_r.bit_cnt != 5'h00);
   assign rx_addr = fifo_data[ADDR_MSB:ADDR_LSB];
   assign rx_wd = fifo_data[WD_BIT];
   assign rx_data = fifo_data[DATA_W-1:0];
   // counter saturates at the timeout
   assign wd_timeout = (st_r.wd_cnt >= WD_CNT_W'(WD_TIMEOUT_CYC - 1));

   // =========================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.sclk_d = sclk_s;
      st_nxt.csn_d = csn_s;
      // drive only while selected and out of pin reset
      st_nxt.so_oe = !csn_s && rstn_s;
      if (csn_fall) begin
         st_nxt.tx_sh = i_status_words[osel*FRAME_BITS +: FRAME_BITS];
         st_nxt.so = i_status_words[osel*FRAME_BITS + FRAME_BITS - 1];
         st_nxt.bit_cnt = 5'h00;
      end else if (!csn_s && sclk_rise) begin
         st_nxt.rx_sh = {st_r.rx_sh[FRAME_BITS-2:0], si_s};
         // received bits follow the loaded word down a chain
         st_nxt.tx_sh = {st_r.tx_sh[FRAME_BITS-2:0], si_s};
         st_nxt.so = st_r.tx_sh[FRAME_BITS-2];
         // top bit sticks once a whole word is in
         st_nxt.bit_cnt = {st_r.bit_cnt[4] | (&st_r.bit_cnt[3:0]),
                           st_r.bit_cnt[3:0] + 4'h1};
      end
      // sticky; only a reset clears it
      if (push && !fifo_ready) begin
         st_nxt.overflow = 1'b1;
      end
      // watchdog
      // runs in normal mode here and in rec_low below
      if (st_r.mode == ST_NORMAL) begin
         st_nxt.wd_cnt = wd_timeout ? st_r.wd_cnt : st_r.wd_cnt + 1'b1;
      end
      if (fifo_valid) begin
         case (st_r.mode)
            ST_NORMAL: begin
               if (rx_wd != st_r.wd_last) begin
                  st_nxt.wd_cnt = '0;
               end
               st_nxt.wd_last = rx_wd;
               case (rx_addr)
                  ADDR_INIT_ONE: st_nxt.init1 = rx_data;
                  ADDR_INIT_TWO: st_nxt.init2 = rx_data;
                  ADDR_CH1: st_nxt.ch[0] = rx_data;
                  ADDR_CH2: st_nxt.ch[1] = rx_data;
                  ADDR_CH3: st_nxt.ch[2] = rx_data;
                  ADDR_CH4: st_nxt.ch[3] = rx_data;
                  ADDR_CH6: st_nxt.ch6 = rx_data;
                  ADDR_OUT_SW: st_nxt.outsw = rx_data;
                  ADDR_GPWM: begin
                     if (rx_data[SUB_BIT]) begin
                        st_nxt.gpwm_duty = rx_data;
                     end else begin
                        st_nxt.gpwm_en = rx_data;
                     end
                  end
                  ADDR_OC: begin
                     if (rx_data[SUB_BIT]) begin
                        st_nxt.oc_hi = rx_data;
                     end else begin
                        st_nxt.oc_lo = rx_data;
                     end
                  end
                  ADDR_IN_EN: st_nxt.in_en = rx_data;
                  ADDR_CLKDIV: begin
                     if (rx_data[SUB_BIT]) begin
                        st_nxt.div6 = rx_data;
                     end else begin
                        st_nxt.div14 = rx_data;
                     end
                  end
                  ADDR_OL: begin
                     if (rx_data[SUB_BIT]) begin
                        st_nxt.olled = rx_data;
                     end else begin
                        st_nxt.ol = rx_data;
                     end
                  end
                  ADDR_STEP: st_nxt.step = rx_data;
                  ADDR_TEST: st_nxt.step = st_r.step;
                  default: st_nxt.step = st_r.step;
               endcase
            end
            ST_FAIL: begin
               st_nxt.wd_cnt = '0;
               // only a toggle-low frame starts recovery
               if (!rx_wd && !i_fail_cause) begin
                  st_nxt.mode = ST_REC_LOW;
               end
            end
            ST_REC_LOW: begin
               // toggle high with no cause restores normal mode
               if (rx_wd && !i_fail_cause) begin
                  st_nxt.mode = ST_NORMAL;
                  st_nxt.spi_fail = 1'b0;
                  st_nxt.wd_last = 1'b1;
                  st_nxt.wd_cnt = '0;
               end else if (!rx_wd) begin
                  st_nxt.mode = ST_REC_LOW;
               end
            end
            default: st_nxt.mode = ST_FAIL;
         endcase
      end
      if (st_r.mode == ST_REC_LOW) begin
         st_nxt.wd_cnt = wd_timeout ? st_r.wd_cnt : st_r.wd_cnt + 1'b1;
         if (wd_timeout) begin
            st_nxt.mode = ST_FAIL;
         end
      end
      // fail entry overrides a word decoded in the same cycle
      if ((st_r.mode == ST_NORMAL) && (wd_timeout || i_fail_cause)) begin
         st_nxt.mode = ST_FAIL;
         st_nxt.spi_fail = wd_timeout;
         {st_nxt.init1, st_nxt.init2, st_nxt.ch, st_nxt.ch6, st_nxt.outsw,
          st_nxt.gpwm_en, st_nxt.gpwm_duty, st_nxt.oc_lo, st_nxt.oc_hi,
          st_nxt.in_en, st_nxt.div14, st_nxt.div6, st_nxt.ol, st_nxt.olled,
          st_nxt.step} = '0;
      end
      // pin reset clears all but the edge history
      if (!rstn_s) begin
         st_nxt = '0;
         st_nxt.sclk_d = sclk_s;
         st_nxt.csn_d = csn_s;
      end
   end

   // =========================================================
   // state register
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // =========================================================
   // registered outputs
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         o_wake <= 1'b0;
         o_fail_mode <= 1'b0;
      end else begin
         o_wake <= rstn_s || (|dir_s);
         // from the next mode, so it lines up with the state
         o_fail_mode <= (st_nxt.mode != ST_NORMAL);
      end
   end

   // =========================================================
   // register contents to ports
   assign o_so = st_r.so;
   assign o_so_oe = st_r.so_oe;
   assign o_spi_fail = st_r.spi_fail;
   assign o_init_config_one = st_r.init1;
   assign o_init_config_two = st_r.init2;
   assign o_channel_six_control = st_r.ch6;
   assign o_output_switch_control = st_r.outsw;
   assign o_global_pwm_enables = st_r.gpwm_en;
   assign o_global_pwm_duty = st_r.gpwm_duty;
   assign o_overcurrent_low_and_mode = st_r.oc_lo;
   assign o_overcurrent_high_options = st_r.oc_hi;
   assign o_direct_input_enable = st_r.in_en;
   assign o_clock_divider_ch1_4 = st_r.div14;
   assign o_clock_divider_ch6 = st_r.div6;
   assign o_open_load_control = st_r.ol;
   assign o_led_open_load_control = st_r.olled;
   assign o_duty_step_adjust = st_r.step;
   assign o_frame_overflow = st_r.overflow;

   // =========================================================
   // channel words, one slice per channel
   for (genvar g = 0; g < 4; g++) begin : g_chan
      assign o_channel_control[g*DATA_W +: DATA_W] = st_r.ch[g];
   end
endmodule : serial_ctrl

// [test/serial_ctrl_props.sv]
// assertion checker for the serial control interface
`timescale 1ns/1ps
module serial_ctrl_props
   import serial_ctrl_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_reset_n_pin,
   input wire logic i_sclk,
   input wire logic i_chip_select_n,
   input wire logic [3:0] i_direct_channel_on_inputs,
   input wire logic i_fail_cause,
   input wire logic o_so,
   input wire logic o_so_oe,
   input wire logic o_wake,
   input wire logic o_fail_mode,
   input wire logic [4*DATA_W-1:0] o_channel_control
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   // ======================================
   // serial pins
   AST_SO_RELEASED: assert property (
      i_chip_select_n [*5] |-> !o_so_oe)
      else $error("so driven while deselected");
   AST_SO_DRIVEN: assert property (
      (!i_chip_select_n && i_reset_n_pin) [*5] |-> o_so_oe)
      else $error("so not driven while selected");
   AST_SO_HOLD_LOW: assert property (
      $fell(i_sclk) && !i_chip_select_n |=> $stable(o_so) [*3])
      else $error("so changed after clock fall");
   AST_COMMIT_DESELECTED: assert property (
      $changed(o_channel_control) && !o_fail_mode |-> i_chip_select_n)
      else $error("register changed inside a frame");
   // ======================================
   // modes
   AST_WAKE_HIGH: assert property (
      (i_reset_n_pin || (|i_direct_channel_on_inputs)) [*5] |-> o_wake)
      else $error("wake low with a wake source");
   AST_WAKE_LOW: assert property (
      !(i_reset_n_pin || (|i_direct_channel_on_inputs)) [*5] |-> !o_wake)
      else $error("wake high without source");
   AST_PIN_CLEARS: assert property (
      !i_reset_n_pin [*5] |-> o_channel_control == '0 && !o_fail_mode)
      else $error("reset pin did not clear");
   AST_FAIL_ENTRY: assert property (
      i_fail_cause |-> ##[1:4] o_fail_mode)
      else $error("fail mode not entered");
   AST_FAIL_CLEARS: assert property (
      $rose(o_fail_mode) |-> ##[0:2] (o_channel_control == '0))
      else $error("fail entry kept settings");
   AST_FAIL_HOLDS: assert property (
      o_fail_mode && $past(o_fail_mode, 3) && i_fail_cause
      |-> o_channel_control == '0)
      else $error("setting written in fail mode");
endmodule : serial_ctrl_props

// [test/spi_master_model.sv]
// master model driving serial frames
`timescale 1ns/1ps
module spi_master_model (
   input wire logic i_ref_clk,
   input wire logic i_so,
   output logic o_sclk,
   output logic o_chip_select_n,
   output logic o_si
);
   logic wd;
   logic [15:0] rx_last;
   initial begin
      o_sclk = 1'b0;
      o_chip_select_n = 1'b1;
      o_si = 1'b0;
      wd = 1'b0;
      rx_last = '0;
   end
   // ======================================
   // frame of n bits, msb first
   task automatic send(input logic [15:0] tx, input int n);
      rx_last = '0;
      @(posedge i_ref_clk);
      o_chip_select_n <= 1'b0;
      o_si <= tx[15];
      repeat (6) @(posedge i_ref_clk);
      for (int k = 0; k < n; k++) begin
         if (k == 0)
            rx_last[15] = i_so;
         o_sclk <= 1'b1;
         repeat (4) @(posedge i_ref_clk);
         if (k < 15)
            rx_last[14-k] = i_so;
         o_sclk <= 1'b0;
         o_si <= (k < 15) ? tx[14-k] : ~tx[0];
         repeat (4) @(posedge i_ref_clk);
      end
      o_chip_select_n <= 1'b1;
      o_si <= ~o_si;
      repeat (12) @(posedge i_ref_clk);
   endtask : send
   task automatic write(input logic [3:0] a, input logic [10:0] d);
      wd = ~wd;
      send({a, wd, d}, 16);
   endtask : write
endmodule : spi_master_model

// [test/serial_ctrl_bench.sv]
// testbench for the serial control interface
`timescale 1ns/1ps
module serial_ctrl_bench;
   import serial_ctrl_pkg::*;
   logic i_ref_clk, i_reset, i_reset_n_pin, i_fail_cause;
   logic i_sclk, i_chip_select_n, i_si;
   logic [3:0] i_direct_channel_on_inputs;
   logic [NUM_REGS*FRAME_BITS-1:0] i_status_words;
   logic o_so, o_so_oe, o_wake, o_spi_fail, o_fail_mode, o_frame_overflow;
   logic [DATA_W-1:0] o_init_config_one, o_global_pwm_enables;
   logic [DATA_W-1:0] o_global_pwm_duty;
   logic [4*DATA_W-1:0] o_channel_control;
   wire logic so_line;
   int err_count = 0;
   int samples_checked = 0;
   assign so_line = o_so_oe ? o_so : 1'bz;
   serial_ctrl u_serial_ctrl (
      .i_ref_clk, .i_reset, .i_reset_n_pin, .i_sclk, .i_chip_select_n,
      .i_si, .i_direct_channel_on_inputs, .i_fail_cause, .i_status_words,
      .o_so, .o_so_oe, .o_wake, .o_spi_fail, .o_fail_mode,
      .o_init_config_one, .o_init_config_two(), .o_channel_control,
      .o_channel_six_control(), .o_output_switch_control(),
      .o_global_pwm_enables, .o_global_pwm_duty,
      .o_overcurrent_low_and_mode(), .o_overcurrent_high_options(),
      .o_direct_input_enable(), .o_clock_divider_ch1_4(),
      .o_clock_divider_ch6(), .o_open_load_control(),
      .o_led_open_load_control(), .o_duty_step_adjust(), .o_frame_overflow);
   spi_master_model u_master (.i_ref_clk, .i_so(so_line),
      .o_sclk(i_sclk), .o_chip_select_n(i_chip_select_n), .o_si(i_si));
   // ======================================
   // checking
   task automatic chk(input string n, input logic [63:0] got,
                      input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task automatic report_and_stop;
      if (err_count == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   task automatic wait_fail(input logic v);
      for (int i = 0; i < 20 && o_fail_mode !== v; i++)
         @(negedge i_ref_clk);
      if (o_fail_mode !== v) begin
         err_count++;
         report_and_stop();
      end
   endtask : wait_fail
   // ======================================
   // scenarios
   task automatic reset_values;
      chk("ch", o_channel_control, '0);
      chk("init1", o_init_config_one, '0);
      chk("oe", o_so_oe, 1'b0);
      chk("wake", o_wake, 1'b1);
      chk("fail", o_fail_mode, 1'b0);
   endtask : reset_values
   task automatic channel_writes;
      logic [43:0] e;
      e = '0;
      for (int c = 0; c < 4; c++) begin
         u_master.write(ADDR_CH1 + 4'(c), 11'h3a5 + 11'(c));
         e[11*c +: 11] = 11'h3a5 + 11'(c);
         if (c == 0)
            chk("word0", u_master.rx_last, 16'h5a00);
      end
      chk("ch", o_channel_control, e);
      chk("duty", o_channel_control[DUTY_LSB +: 8], 8'ha5);
      chk("on", o_channel_control[CHON_BIT], 1'b1);
      chk("phase", o_channel_control[PHASE_LSB +: 2], 2'b01);
   endtask : channel_writes
   task automatic sub_select;
      u_master.write(ADDR_GPWM, 11'h017);
      u_master.write(ADDR_GPWM, 11'h4c3);
      chk("gen", o_global_pwm_enables[9:0], 10'h017);
      chk("gduty", o_global_pwm_duty[9:0], 10'h0c3);
      u_master.write(ADDR_TEST, 11'h7ff);
      chk("ch1", o_channel_control[10:0], 11'h3a5);
      chk("gduty", o_global_pwm_duty[9:0], 10'h0c3);
      u_master.send({ADDR_CH1, 12'h000}, 8);
      chk("ch1", o_channel_control[10:0], 11'h3a5);
   endtask : sub_select
   task automatic word_select;
      u_master.write(ADDR_INIT_ONE, 11'h005);
      chk("init1", o_init_config_one[OSEL_LSB +: 4], 4'h5);
      u_master.write(ADDR_TEST, 11'h000);
      chk("word5", u_master.rx_last, 16'h5a05);
   endtask : word_select
   task automatic fail_path;
      @(posedge i_ref_clk) i_fail_cause <= 1'b1;
      wait_fail(1'b1);
      repeat (3) @(negedge i_ref_clk);
      chk("ch", o_channel_control, '0);
      chk("init1", o_init_config_one, '0);
      chk("spifail", o_spi_fail, 1'b0);
      u_master.write(ADDR_CH2, 11'h155);
      chk("ch", o_channel_control, '0);
      @(posedge i_ref_clk) i_fail_cause <= 1'b0;
      u_master.wd = 1'b1;
      u_master.write(ADDR_CH2, 11'h155);
      u_master.write(ADDR_CH2, 11'h155);
      wait_fail(1'b0);
      u_master.write(ADDR_CH3, 11'h0f0);
      chk("ch3", o_channel_control[22 +: 11], 11'h0f0);
   endtask : fail_path
   task automatic pin_reset;
      u_master.write(ADDR_CH2, 11'h2aa);
      @(posedge i_ref_clk) i_reset_n_pin <= 1'b0;
      i_direct_channel_on_inputs <= 4'h4;
      repeat (8) @(negedge i_ref_clk);
      chk("ch", o_channel_control, '0);
      chk("wake", o_wake, 1'b1);
      @(posedge i_ref_clk) i_direct_channel_on_inputs <= 4'h0;
      repeat (8) @(negedge i_ref_clk);
      chk("wake", o_wake, 1'b0);
      @(posedge i_ref_clk) i_reset_n_pin <= 1'b1;
      repeat (8) @(negedge i_ref_clk);
      chk("wake", o_wake, 1'b1);
      chk("ovf", o_frame_overflow, 1'b0);
   endtask : pin_reset
   // ======================================
   // clock and sequence
   initial begin
      i_ref_clk = 1'b0;
      forever #50 i_ref_clk = ~i_ref_clk;
   end
   initial begin
      i_reset = 1'b1;
      i_reset_n_pin = 1'b1;
      i_fail_cause = 1'b0;
      i_direct_channel_on_inputs = 4'h0;
      for (int n = 0; n < 16; n++)
         i_status_words[16*n +: 16] = 16'h5a00 + 16'(n);
      repeat (20) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      repeat (6) @(negedge i_ref_clk);
      reset_values();
      channel_writes();
      sub_select();
      word_select();
      fail_path();
      pin_reset();
      report_and_stop();
   end
endmodule : serial_ctrl_bench
bind serial_ctrl serial_ctrl_props u_props (
   .i_ref_clk, .i_reset, .i_reset_n_pin, .i_sclk, .i_chip_select_n,
   .i_direct_channel_on_inputs, .i_fail_cause, .o_so, .o_so_oe, .o_wake,
   .o_fail_mode, .o_channel_control);
